// ==== ivw_pkg.sv ====
`default_nettype none
package ivw_pkg;
  // source indices, highest priority first (table order)
  localparam int NSRC = 13;
  localparam int SRC_W = 4;

  localparam logic [8:0] OFS_SEQ_ABORT  = 9'h188;
  localparam logic [8:0] OFS_CONV_DONE  = 9'h184;
  localparam logic [8:0] OFS_BATTERY    = 9'h140;
  localparam logic [8:0] OFS_PORT_S     = 9'h124;
  localparam logic [8:0] OFS_OVERCUR    = 9'h108;
  localparam logic [8:0] OFS_PERIODIC   = 9'h100;
  localparam logic [8:0] OFS_PORT_AD    = 9'h0f4;
  localparam logic [8:0] OFS_PORT_L     = 9'h0c0;
  localparam logic [8:0] OFS_TIM_CH0    = 9'h0ac;
  localparam logic [8:0] OFS_TIM_CH1    = 9'h0a8;
  localparam logic [8:0] OFS_TIM_CH2    = 9'h0a4;
  localparam logic [8:0] OFS_TIM_CH3    = 9'h0a0;
  localparam logic [8:0] OFS_TIM_OVF    = 9'h08c;
  localparam logic [8:0] OFS_RSVD_HI    = 9'h088;
  localparam logic [8:0] OFS_RSVD_LO    = 9'h064;
  localparam logic [8:0] OFS_ENTRY_STEP = 9'h004;

  // register byte addresses
  localparam logic [11:0] ADDR_BASE    = 12'h000;
  localparam logic [11:0] ADDR_CTRL    = 12'h004;
  localparam logic [11:0] ADDR_EN0     = 12'h008;
  localparam logic [11:0] ADDR_EN1     = 12'h00c;
  localparam logic [11:0] ADDR_PEND    = 12'h010;
  localparam logic [11:0] ADDR_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_MASK    = 12'h018;
  localparam logic [11:0] ADDR_VECTOR  = 12'h01c;

  localparam logic [31:0] BASE_RST     = 32'h0000_0000;
  localparam logic        GMASK_RST    = 1'b1;
  localparam int          GMASK_BIT    = 0;

  // enable field positions in en0 / en1
  localparam int EN0_SEQ_ABORT = 0;
  localparam int EN0_CONIF_OVF = 1;
  localparam int EN0_CONV_LSB  = 2;
  localparam int EN0_SUP_HIGH  = 12;
  localparam int EN0_SUP_LOW   = 13;
  localparam int EN0_PORT_S    = 16;
  localparam int EN0_OVC_LSB   = 24;
  localparam int EN1_PERIODIC  = 0;
  localparam int EN1_PORT_L    = 1;
  localparam int EN1_TIM_LSB   = 3;
  localparam int EN1_AD_LOW    = 8;
  localparam int EN1_AD_HIGH   = 16;
  localparam int EN1_OVF       = 24;
  localparam logic [6:0] OVC_VALID = 7'h57;

  typedef struct packed {
    logic [1:0] seq_abort;
    logic [9:0] conv_done;
    logic [1:0] battery;
    logic [7:0] port_s;
    logic [6:0] overcur;
    logic       periodic;
    logic [15:0] port_ad;
    logic [1:0] port_l;
    logic [3:0] tim_ch;
    logic       tim_ovf;
  } ivw_flags_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] src;
    logic [31:0] addr;
  } ivw_vec_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ivw_apb_req_t;
endpackage
`default_nettype wire

// ==== ivw_gate.sv ====
`default_nettype none
module ivw_gate (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire ivw_pkg::ivw_flags_t flags,
  input  wire logic [31:0]       en0,
  input  wire logic [31:0]       en1,
  output logic [12:0]            req
);
  import ivw_pkg::*;
  logic [12:0] req_next;

  // per-source local-enable gating, index 0 = highest priority
  always_comb begin
    req_next[0]  = (flags.seq_abort[0] & en0[EN0_SEQ_ABORT]) |
                   (flags.seq_abort[1] & en0[EN0_CONIF_OVF]);
    req_next[1]  = |(flags.conv_done & en0[EN0_CONV_LSB +: 10]);
    req_next[2]  = (flags.battery[1] & en0[EN0_SUP_HIGH]) |
                   (flags.battery[0] & en0[EN0_SUP_LOW]);
    req_next[3]  = |(flags.port_s & en0[EN0_PORT_S +: 8]);
    req_next[4]  = |(flags.overcur & en0[EN0_OVC_LSB +: 7] &
                     OVC_VALID);
    req_next[5]  = flags.periodic & en1[EN1_PERIODIC];
    req_next[6]  = |(flags.port_ad & {en1[EN1_AD_HIGH +: 8],
                                      en1[EN1_AD_LOW +: 8]});
    req_next[7]  = |(flags.port_l & en1[EN1_PORT_L +: 2]);
    req_next[11:8] = flags.tim_ch & en1[EN1_TIM_LSB +: 4];
    req_next[12] = flags.tim_ovf & en1[EN1_OVF];
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      req <= 13'h0000;
    end else if (clk_en) begin
      req <= req_next;
    end
  end
endmodule
`default_nettype wire

// ==== ivw_prio.sv ====
`default_nettype none
module ivw_prio (
  input  wire logic              mclk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  input  wire logic [12:0]       req,
  input  wire logic [31:0]       base,
  output ivw_pkg::ivw_vec_t      vec
);
  import ivw_pkg::*;
  localparam logic [8:0] OFS_TAB [13] = '{OFS_SEQ_ABORT, OFS_CONV_DONE,
    OFS_BATTERY, OFS_PORT_S, OFS_OVERCUR, OFS_PERIODIC, OFS_PORT_AD,
    OFS_PORT_L, OFS_TIM_CH0, OFS_TIM_CH1, OFS_TIM_CH2, OFS_TIM_CH3,
    OFS_TIM_OVF};
  ivw_vec_t vec_next;

  always_comb begin
    vec_next = '0;
    // lowest index wins: table order is priority order
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        vec_next.valid = 1'b1;
        vec_next.src   = SRC_W'(i);
        vec_next.addr  = base + {23'h0, OFS_TAB[i]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      vec <= '0;
    end else if (clk_en) begin
      vec <= vec_next;
    end
  end
endmodule
`default_nettype wire

// ==== ivw_top.sv ====
`default_nettype none
// Function
// - each vector address is the base register plus a fixed source offset.
// - simultaneous requests resolve by fixed table order, high offset first.
// - sequence abort uses 0x188, gated by two enables, idle-sleep wake only.
// - conversion complete uses 0x184, gated by ten enables, idle wake only.
// - supply monitor uses 0x140, gated by high/low enables, idle wake only.
// - port s key wake uses 0x124, eight pin enables, wakes deep and idle.
// - over-current uses 0x108, enables on bits 6, 4 and 2:0, idle wake only.
// - periodic interrupt uses 0x100, single enable, wakes deep and idle.
// - port ad key wake uses 0x0f4, two eight-bit enables, wakes deep and idle.
// - port l key wake uses 0x0c0, two pin enables, wakes deep and idle.
// - timer channels 0-3 use 0x0ac..0x0a0, overflow 0x08c, idle wake only.
// - offsets 0x088 down to 0x064 carry no source and are reserved.
module ivw_top (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  input  wire ivw_pkg::ivw_flags_t flags,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                core_ack,
  output logic                     core_irq,
  output logic [31:0]              core_vector,
  output logic                     core_vector_valid,
  output logic                     wake_deep,
  output logic                     wake_idle,
  output logic                     irq
);
  import ivw_pkg::*;

  // wake capability per source, fixed
  localparam logic [12:0] WAKE_DEEP_MAP = 13'h00e8;
  localparam logic [12:0] WAKE_IDLE_MAP = 13'h1fff;

  logic [31:0] vector_base_reg;
  logic        gmask_reg;
  logic [31:0] en0_reg;
  logic [31:0] en1_reg;
  logic [12:0] status_reg;
  logic [12:0] mask_reg;
  logic [12:0] req;
  logic [12:0] req_prev;
  ivw_vec_t    vec;
  logic        apb_wr;
  logic        apb_rd;
  logic        addr_ok;
  logic [31:0] rd_next;

  ivw_gate u_gate (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .flags   (flags),
    .en0     (en0_reg),
    .en1     (en1_reg),
    .req     (req)
  );

  ivw_prio u_prio (
    .mclk    (mclk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .req     (req),
    .base    (vector_base_reg),
    .vec     (vec)
  );

  assign apb_wr = psel & penable & pwrite & ~pready;
  assign apb_rd = psel & penable & ~pwrite & ~pready;

  always_comb begin
    addr_ok = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      ADDR_BASE:   rd_next = vector_base_reg;
      ADDR_CTRL:   rd_next = {31'h0, gmask_reg};
      ADDR_EN0:    rd_next = en0_reg;
      ADDR_EN1:    rd_next = en1_reg;
      ADDR_PEND:   rd_next = {19'h0, req};
      ADDR_STATUS: rd_next = {19'h0, status_reg};
      ADDR_MASK:   rd_next = {19'h0, mask_reg};
      ADDR_VECTOR: rd_next = vec.addr;
      default:     addr_ok = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~addr_ok;
      if (apb_rd) begin
        prdata <= rd_next;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      vector_base_reg <= BASE_RST;
      gmask_reg       <= GMASK_RST;
      en0_reg         <= 32'h0000_0000;
      en1_reg         <= 32'h0000_0000;
      mask_reg        <= 13'h0000;
    end else if (clk_en && apb_wr) begin
      case (paddr)
        ADDR_BASE: vector_base_reg <= {pwdata[31:9], 9'h000};
        ADDR_CTRL: gmask_reg <= pwdata[GMASK_BIT];
        ADDR_EN0:  en0_reg <= pwdata;
        ADDR_EN1:  en1_reg <= pwdata;
        ADDR_MASK: mask_reg <= pwdata[12:0];
        default:   ;
      endcase
    end
  end

  // sticky on rising request; read clears, a new event wins
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      status_reg <= 13'h0000;
      req_prev   <= 13'h0000;
    end else if (clk_en) begin
      req_prev <= req;
      if (apb_rd && paddr == ADDR_STATUS) begin
        status_reg <= req & ~req_prev;
      end else begin
        status_reg <= status_reg | (req & ~req_prev);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // core side: mask gate, vector latched on ack
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      core_irq          <= 1'b0;
      core_vector       <= 32'h0000_0000;
      core_vector_valid <= 1'b0;
    end else if (clk_en) begin
      core_irq <= vec.valid & ~gmask_reg;
      core_vector_valid <= 1'b0;
      if (core_ack && vec.valid && !gmask_reg) begin
        core_vector       <= vec.addr;
        core_vector_valid <= 1'b1;
      end
    end
  end

  // wake works even under global mask, like sleep exit logic
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wake_deep <= 1'b0;
      wake_idle <= 1'b0;
    end else if (clk_en) begin
      wake_deep <= |(req & WAKE_DEEP_MAP);
      wake_idle <= |(req & WAKE_IDLE_MAP);
    end
  end
endmodule
`default_nettype wire

// ==== ivw_top_chk.sv ====
`default_nettype none
module ivw_top_chk (
  input wire logic                mclk,
  input wire logic                reset_n,
  input wire logic                clk_en,
  input wire ivw_pkg::ivw_flags_t flags,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                core_ack,
  input wire logic                core_irq,
  input wire logic [31:0]         core_vector,
  input wire logic                core_vector_valid,
  input wire logic                wake_deep,
  input wire logic                wake_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  import ivw_pkg::*;
  logic        gm_q;
  logic [31:0] base_q;
  // shadow copies, taken at the same edge as the design
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gm_q   <= GMASK_RST;
      base_q <= BASE_RST;
    end else if (psel && penable && !pready && pwrite && clk_en) begin
      if (paddr == ADDR_CTRL) gm_q <= pwdata[GMASK_BIT];
      if (paddr == ADDR_BASE) base_q <= pwdata;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    psel && penable && !pready && clk_en;
  endsequence
  sequence s_quiet;
    (flags == '0 && clk_en) [*4];
  endsequence
  sequence s_no_deep;
    (flags.port_s == '0 && !flags.periodic && flags.port_ad == '0
     && flags.port_l == '0 && clk_en) [*4];
  endsequence
  property p_ready;
    s_take |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("pready not a single cycle after access");
  property p_ack;
    $rose(core_ack) && core_irq && clk_en |=> core_vector_valid;
  endproperty
  a_ack: assert property (p_ack)
    else $error("no vector after ack");
  property p_cause;
    core_vector_valid |-> $past(core_ack);
  endproperty
  a_cause: assert property (p_cause)
    else $error("vector without ack");
  property p_step;
    core_vector_valid |-> core_vector[1:0] == 2'b00;
  endproperty
  a_step: assert property (p_step)
    else $error("vector not word spaced");
  property p_rsvd;
    core_vector_valid |->
      !(core_vector[8:0] inside {[OFS_RSVD_LO:OFS_RSVD_HI]});
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("vector in reserved range");
  property p_base;
    core_vector_valid |-> core_vector[31:9] == base_q[31:9];
  endproperty
  a_base: assert property (p_base)
    else $error("vector not on base");
  property p_gmask;
    gm_q && $past(gm_q, 3) |-> !core_irq;
  endproperty
  a_gmask: assert property (p_gmask)
    else $error("irq while globally masked");
  property p_quiet;
    s_quiet |-> !core_irq;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("irq with no request");
  property p_no_deep;
    s_no_deep |-> !wake_deep;
  endproperty
  a_no_deep: assert property (p_no_deep)
    else $error("deep wake from idle-only source");
  property p_deep_idle;
    wake_deep |-> wake_idle;
  endproperty
  a_deep_idle: assert property (p_deep_idle)
    else $error("deep wake without idle wake");
endmodule
bind ivw_top ivw_top_chk u_chk (.*);
`default_nettype wire

// ==== ivw_core_mdl.sv ====
`default_nettype none
module ivw_core_mdl (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        core_irq,
  input  wire logic [31:0] core_vector,
  input  wire logic        core_vector_valid,
  input  wire logic [1:0]  dly,
  input  wire logic        clr,
  output logic             core_ack,
  output logic [31:0]      last_vec,
  output logic             got
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  // ack held until the vector comes; dly makes a slow core
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      core_ack <= 1'b0;
      cnt      <= 2'h0;
      got      <= 1'b0;
    end else if (core_vector_valid) begin
      last_vec <= core_vector;
      got      <= 1'b1;
      core_ack <= 1'b0;
    end else begin
      if (clr) got <= 1'b0;
      // one ack per served request; a late ack would race the withdrawn irq
      if (core_irq && !core_ack && !got) begin
        core_ack <= (cnt == dly);
        cnt      <= (cnt == dly) ? 2'h0 : cnt + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== ivw_top_tb_top.sv ====
`default_nettype none
module ivw_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ivw_pkg::*;
  localparam logic [8:0] OFS [13] = '{OFS_SEQ_ABORT, OFS_CONV_DONE,
    OFS_BATTERY, OFS_PORT_S, OFS_OVERCUR, OFS_PERIODIC, OFS_PORT_AD,
    OFS_PORT_L, OFS_TIM_CH0, OFS_TIM_CH1, OFS_TIM_CH2, OFS_TIM_CH3,
    OFS_TIM_OVF};
  localparam logic [12:0] DEEP = 13'h0e8;
  logic        mclk, reset_n, clk_en, psel, penable, pwrite, pready;
  logic        pslverr, core_ack, core_irq, core_vector_valid, irq;
  logic        wake_deep, wake_idle, got, clr, err;
  logic [1:0]  dly;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, core_vector, last_vec, rd, r, bv;
  ivw_flags_t  flags;
  int          err_total, n_checks, i, j;
  ivw_top DUT (.*);
  ivw_core_mdl u_core (.*);
  function automatic logic [31:0] xs();
    r = r ^ (r << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  // one source raised; bit 0 forced so the pattern is never empty
  function automatic ivw_flags_t fl(input int s, input logic [31:0] v);
    ivw_flags_t f;
    f = '0;
    v = v | 32'h1;
    case (s)
      0: f.seq_abort = v[1:0];
      1: f.conv_done = v[9:0];
      2: f.battery = v[1:0];
      3: f.port_s = v[7:0];
      4: f.overcur = v[6:0] & OVC_VALID;
      5: f.periodic = 1'b1;
      6: f.port_ad = v[15:0];
      7: f.port_l = v[1:0];
      8, 9, 10, 11: f.tim_ch[s-8] = 1'b1;
      default: f.tim_ovf = 1'b1;
    endcase
    return f;
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task end_sim();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) err_total++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task run(input ivw_flags_t f, input int e, input logic dp);
    int k;
    clr   <= 1'b1;
    @(posedge mclk);
    clr   <= 1'b0;
    flags <= f;
    for (k = 0; k < 60; k++) begin
      @(posedge mclk);
      if (got === 1'b1) break;
    end
    chk(last_vec, bv + {23'h0, OFS[e]});
    chk(wake_deep, dp);
    chk(wake_idle, 1'b1);
    flags <= '0;
    repeat (6) @(posedge mclk);
  endtask
  task no_irq(input ivw_flags_t f);
    flags <= f;
    repeat (8) @(posedge mclk);
    chk(core_irq, 1'b0);
    flags <= '0;
    repeat (4) @(posedge mclk);
  endtask
  task pulse5();
    flags <= fl(5, 0);
    @(posedge mclk);
    flags <= '0;
    repeat (6) @(posedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    end_sim();
  end
  initial begin
    {reset_n, psel, penable, pwrite, clr} = '0;
    {paddr, pwdata, flags, dly} = '0;
    clk_en = 1'b1;
    r = 32'd38;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b0, ADDR_CTRL, 0);
    chk(rd[0], GMASK_RST);
    apb(1'b0, 12'h040, 0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    bv = xs() & 32'hffff_fe00;
    apb(1'b1, ADDR_BASE, bv);
    apb(1'b0, ADDR_BASE, 0);
    chk(rd, bv);
    apb(1'b1, ADDR_EN0, '1);
    apb(1'b1, ADDR_EN1, '1);
    no_irq(fl(0, xs()));
    apb(1'b1, ADDR_CTRL, 0);
    for (i = 0; i < 13; i++) begin
      dly <= xs() % 4;
      run(fl(i, xs()), i, DEEP[i]);
    end
    for (i = 0; i < 8; i++) begin
      j = xs() % 13;
      run(fl(i, xs()) | fl(j, xs()), j < i ? j : i, DEEP[i] | DEEP[j]);
    end
    no_irq('{overcur: 7'h28, default: '0});
    apb(1'b1, ADDR_EN0, 0);
    no_irq(fl(0, xs()));
    apb(1'b0, ADDR_STATUS, 0);
    apb(1'b1, ADDR_MASK, 32'h20);
    pulse5();
    chk(irq, 1'b1);
    apb(1'b0, ADDR_STATUS, 0);
    chk(rd, 32'h20);
    apb(1'b0, ADDR_STATUS, 0);
    chk({rd[5], irq}, 0);
    apb(1'b1, ADDR_MASK, 0);
    pulse5();
    chk(irq, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
